// ==== hdl/smbtm_monitor.sv ====
// Bus link timing monitor: timeouts, idle reset, master clock, stretch budgets
//
// Operation
// - Abandon transaction when clock low exceeds timeout
// - Clock high over 50 us resets transaction
// - Master mode drives clock at 51.2 kHz
// - Own slave stretching per message capped 25 ms
// - Bus-off after 2 s both low; recover
// - Master mode per bus v1.1
`timescale 1ns/1ps
`default_nettype none
module smbtm_monitor #(
   parameter int unsigned TIMEOUT_CYC = smbtm_pkg::TIMEOUT_CYC,
   parameter int unsigned SLV_BUDGET_CYC = smbtm_pkg::SLV_BUDGET_CYC,
   parameter int unsigned MST_BUDGET_CYC = smbtm_pkg::MST_BUDGET_CYC,
   parameter int unsigned BUSOFF_CYC = smbtm_pkg::BUSOFF_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic bus_clock_line_i,
   input wire logic bus_data_line_i,
   input wire logic master_req,
   input wire logic stretch_req,
   output logic bus_clock_line_o,
   output logic bus_clock_line_oe,
   output logic bus_data_line_oe,
   output logic in_message,
   output logic xact_abort,
   output logic bus_off,
   output logic bus_ready,
   output logic slave_budget_over,
   output logic master_budget_over,
   output logic master_active
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic scl_m, scl_s, sda_m, sda_s, sda_d;
   // Two flops per pin, third stage on data only for edge finding
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_m <= bus_clock_line_i;
         scl_s <= scl_m;
         sda_m <= bus_data_line_i;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end
   logic start_ev, stop_ev;
   assign start_ev = scl_s && sda_d && !sda_s;
   assign stop_ev = scl_s && !sda_d && sda_s;

   // ---------------------------------------------------------------
   // Interval counters
   // ---------------------------------------------------------------
   logic [smbtm_pkg::CNT_W-1:0] low_cnt, high_cnt, both_low_cnt, rec_cnt;
   logic [smbtm_pkg::CNT_W-1:0] slv_cnt, mst_cnt;
   logic low_to, idle_to, both_low_to;
   assign low_to = (low_cnt >= smbtm_pkg::CNT_W'(TIMEOUT_CYC));
   assign idle_to = (high_cnt >= smbtm_pkg::CNT_W'(smbtm_pkg::IDLE_CYC));
   assign both_low_to = (both_low_cnt >= smbtm_pkg::CNT_W'(BUSOFF_CYC));

   function automatic logic [smbtm_pkg::CNT_W-1:0] sat_inc(
      input logic [smbtm_pkg::CNT_W-1:0] v);
      sat_inc = (&v) ? v : v + smbtm_pkg::CNT_W'(1);
   endfunction

   // Clock low and high run lengths
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         low_cnt <= '0;
         high_cnt <= '0;
         both_low_cnt <= '0;
      end else begin
         low_cnt <= scl_s ? '0 : sat_inc(low_cnt);
         // A start restarts the high count, so idle time before it is not held against it
         high_cnt <= (scl_s && !start_ev) ? sat_inc(high_cnt) : '0;
         both_low_cnt <= (scl_s || sda_s) ? '0 : sat_inc(both_low_cnt);
      end
   end

   // ---------------------------------------------------------------
   // Transaction state
   // ---------------------------------------------------------------
   smbtm_pkg::smbtm_state_e state;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= smbtm_pkg::SMBTM_IDLE;
      end else begin
         case (state)
            smbtm_pkg::SMBTM_IDLE: begin
               if (both_low_to) state <= smbtm_pkg::SMBTM_BUS_OFF;
               else if (start_ev) state <= smbtm_pkg::SMBTM_ACTIVE;
            end
            smbtm_pkg::SMBTM_ACTIVE: begin
               if (both_low_to) state <= smbtm_pkg::SMBTM_BUS_OFF;
               else if (low_to || idle_to) state <= smbtm_pkg::SMBTM_WAIT_START;
               else if (stop_ev) state <= smbtm_pkg::SMBTM_IDLE;
            end
            smbtm_pkg::SMBTM_WAIT_START: begin
               if (both_low_to) state <= smbtm_pkg::SMBTM_BUS_OFF;
               else if (start_ev) state <= smbtm_pkg::SMBTM_ACTIVE;
            end
            smbtm_pkg::SMBTM_BUS_OFF: begin
               if (scl_s || sda_s) state <= smbtm_pkg::SMBTM_IDLE;
            end
            default: state <= smbtm_pkg::SMBTM_IDLE;
         endcase
      end
   end

   // Abort pulse, message flag and bus-off flag
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         xact_abort <= 1'b0;
         in_message <= 1'b0;
         bus_off <= 1'b0;
      end else begin
         xact_abort <= (state == smbtm_pkg::SMBTM_ACTIVE) && (low_to || idle_to);
         in_message <= (state == smbtm_pkg::SMBTM_ACTIVE);
         bus_off <= (state == smbtm_pkg::SMBTM_BUS_OFF);
      end
   end

   // Recovery count: ready within 1 ms of leaving bus-off
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rec_cnt <= '0;
         bus_ready <= 1'b1;
      end else if (state == smbtm_pkg::SMBTM_BUS_OFF) begin
         rec_cnt <= '0;
         bus_ready <= 1'b0;
      end else if (!bus_ready) begin
         rec_cnt <= sat_inc(rec_cnt);
         bus_ready <= (rec_cnt >= smbtm_pkg::CNT_W'(smbtm_pkg::RECOVER_CYC - 1));
      end
   end

   // ---------------------------------------------------------------
   // Master clock generator
   // ---------------------------------------------------------------
   logic [7:0] div_cnt;
   logic mclk_low;
   logic mst_go;
   assign mst_go = master_req && bus_ready && (state != smbtm_pkg::SMBTM_WAIT_START)
                   && (state != smbtm_pkg::SMBTM_BUS_OFF);
   // Half-period divider; held at zero while a slave holds the clock low
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_cnt <= '0;
         mclk_low <= 1'b0;
         master_active <= 1'b0;
      end else begin
         master_active <= mst_go;
         if (!mst_go) begin
            div_cnt <= '0;
            mclk_low <= 1'b0;
         end else if (!mclk_low && !scl_s) begin
            div_cnt <= '0; // stretched by slave: wait for release
         end else if (div_cnt == 8'(smbtm_pkg::MCLK_HALF_CYC - 1)) begin
            div_cnt <= '0;
            mclk_low <= !mclk_low;
         end else begin
            div_cnt <= div_cnt + 8'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // Stretch budgets per message
   // ---------------------------------------------------------------
   logic own_stretch;
   assign own_stretch = stretch_req && in_message && !master_active &&
                        (slv_cnt < smbtm_pkg::CNT_W'(SLV_BUDGET_CYC));
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         slv_cnt <= '0;
         mst_cnt <= '0;
         slave_budget_over <= 1'b0;
         master_budget_over <= 1'b0;
      end else if (state != smbtm_pkg::SMBTM_ACTIVE) begin
         slv_cnt <= '0;
         mst_cnt <= '0;
         slave_budget_over <= 1'b0;
         master_budget_over <= 1'b0;
      end else begin
         if (bus_clock_line_oe && !mclk_low) slv_cnt <= sat_inc(slv_cnt);
         // Extension by outside master: clock low beyond a nominal low phase
         if (!master_active && !scl_s && !bus_clock_line_oe &&
             low_cnt > smbtm_pkg::CNT_W'(smbtm_pkg::MCLK_HALF_CYC))
            mst_cnt <= sat_inc(mst_cnt);
         slave_budget_over <= (slv_cnt >= smbtm_pkg::CNT_W'(SLV_BUDGET_CYC));
         master_budget_over <= (mst_cnt >= smbtm_pkg::CNT_W'(MST_BUDGET_CYC));
      end
   end

   // Pin drive: released whenever a transaction is dropped
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_clock_line_o <= 1'b0;
         bus_clock_line_oe <= 1'b0;
         bus_data_line_oe <= 1'b0;
      end else begin
         bus_clock_line_o <= 1'b0;
         // Own stretch starts only once the clock is already low, never cutting a high phase
         bus_clock_line_oe <= (master_active && mclk_low) ||
                              (own_stretch && (bus_clock_line_oe || !scl_s));
         bus_data_line_oe <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   abort_timeout_a: assert property (@(posedge clk) disable iff (reset)
      (state == smbtm_pkg::SMBTM_ACTIVE && low_to) |=> xact_abort)
      else $error("clock low timeout did not abort");
   idle_reset_a: assert property (@(posedge clk) disable iff (reset)
      (state == smbtm_pkg::SMBTM_ACTIVE && idle_to && !both_low_to) |=>
      state == smbtm_pkg::SMBTM_WAIT_START)
      else $error("idle clock did not reset transaction");
   master_half_a: assert property (@(posedge clk) disable iff (reset)
      (mst_go && $rose(mclk_low)) |-> $past(div_cnt) == 8'(smbtm_pkg::MCLK_HALF_CYC - 1))
      else $error("master clock half period wrong");
   slave_budget_a: assert property (@(posedge clk) disable iff (reset)
      (slv_cnt >= smbtm_pkg::CNT_W'(SLV_BUDGET_CYC) && !master_active) |=>
      !bus_clock_line_oe)
      else $error("slave stretch beyond budget");
   bus_off_a: assert property (@(posedge clk) disable iff (reset)
      (both_low_to && !scl_s && !sda_s) |=> ##1 bus_off)
      else $error("bus-off not entered");
   release_lines_a: assert property (@(posedge clk) disable iff (reset)
      (state == smbtm_pkg::SMBTM_WAIT_START) [*3] |->
      !bus_clock_line_oe && !bus_data_line_oe && !master_active)
      else $error("lines held while waiting for start");
   cover_msg_c: cover property (@(posedge clk) disable iff (reset) $rose(in_message));
   cover_abort_c: cover property (@(posedge clk) disable iff (reset) xact_abort);
   cover_master_c: cover property (@(posedge clk) disable iff (reset) $rose(mclk_low));
endmodule // smbtm_monitor
`default_nettype wire

// ==== hdl/smbtm_pkg.sv ====
// Package of timing constants and types for the bus link timing monitor
package smbtm_pkg;
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned CLK_NS = 100;
   // Clock-low timeout window, in ms
   localparam int unsigned TIMEOUT_MIN_MS = 25;
   localparam int unsigned TIMEOUT_MAX_MS = 35;
   localparam int unsigned TIMEOUT_CYC = (TIMEOUT_MIN_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   // Clock-high idle limit, in us
   localparam int unsigned IDLE_US = 50;
   localparam int unsigned IDLE_CYC = (IDLE_US * 1000 + CLK_NS - 1) / CLK_NS;
   // Master clock rate, in Hz (51.2 kHz), half period rounded down
   localparam int unsigned MCLK_HZ = 51200;
   localparam int unsigned MCLK_HALF_CYC = CLK_HZ / (2 * MCLK_HZ);
   // Stretch budgets, in ms
   localparam int unsigned SLV_BUDGET_MS = 25;
   localparam int unsigned MST_BUDGET_MS = 10;
   localparam int unsigned SLV_BUDGET_CYC = SLV_BUDGET_MS * 1000000 / CLK_NS;
   localparam int unsigned MST_BUDGET_CYC = MST_BUDGET_MS * 1000000 / CLK_NS;
   // Bus-off detect and recovery, in ms
   localparam int unsigned BUSOFF_MS = 2000;
   localparam int unsigned BUSOFF_CYC = BUSOFF_MS * 10000;
   localparam int unsigned RECOVER_MS = 1;
   localparam int unsigned RECOVER_CYC = RECOVER_MS * 1000000 / CLK_NS;
   localparam int unsigned CNT_W = 25;
   typedef enum logic [1:0] {
      SMBTM_IDLE = 2'b00,
      SMBTM_ACTIVE = 2'b01,
      SMBTM_WAIT_START = 2'b10,
      SMBTM_BUS_OFF = 2'b11
   } smbtm_state_e;
endpackage

// ==== tb/smbtm_host_model.sv ====
// Behavioural host and charger driving the far side of the bus pins
`timescale 1ns/1ps
`default_nettype none
module smbtm_host_model (
   input wire logic clk,
   input wire logic scl,
   output logic clk_low,
   output logic dat_low
);
   initial begin
      clk_low = 1'b0;
      dat_low = 1'b0;
   end
   // Holds or lets go of both lines until told otherwise
   task automatic drive(input logic c, input logic d);
      clk_low <= c;
      dat_low <= d;
   endtask
   // Waits a number of system clock cycles
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Pulls the clock low, lets go, then waits while a slave still stretches it
   task automatic hold(input int n);
      int k;
      clk_low <= 1'b1;
      idle(n);
      clk_low <= 1'b0;
      k = 0;
      @(posedge clk);
      while (scl !== 1'b1 && k < 400) begin
         @(posedge clk);
         k++;
      end
   endtask
   // Start: data falls with clock high, data let go once the clock is low
   task automatic start();
      dat_low <= 1'b1;
      idle(4);
      clk_low <= 1'b1;
      idle(2);
      dat_low <= 1'b0;
      hold(2);
   endtask
   // Clock pulses at an even duty cycle, 800 ns each
   task automatic pulse(input int n);
      repeat (n) begin
         hold(4);
         idle(3);
      end
   endtask
   // Stop: data rises while the clock is high
   task automatic stop();
      clk_low <= 1'b1;
      dat_low <= 1'b1;
      hold(4);
      idle(4);
      dat_low <= 1'b0;
      idle(6);
   endtask
endmodule // smbtm_host_model
`default_nettype wire

// ==== tb/smbtm_monitor_tb.sv ====
// Self-checking bench for the bus link timing monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
   $display("ERROR %0t value mismatch", $time); end end
module smbtm_monitor_tb;
   // Shortened limits so each scenario stays brief
   localparam int unsigned TB_TIMEOUT_CYC = 200;
   localparam int unsigned TB_SLV_BUDGET_CYC = 400;
   localparam int unsigned TB_MST_BUDGET_CYC = 100;
   localparam int unsigned TB_BUSOFF_CYC = 50;
   logic clk;
   logic reset;
   logic master_req;
   logic stretch_req;
   logic clk_low, dat_low, scl_o, scl_oe, sda_oe, in_message, xact_abort, bus_off;
   logic bus_ready, slave_budget_over, master_budget_over, master_active;
   wire logic scl = !(clk_low || scl_oe);
   wire logic sda = !(dat_low || sda_oe);
   int failures = 0;
   int total_checks = 0;
   int aborts = 0;
   int cycles = 0;
   int k;
   always #50 clk = !clk;
   smbtm_monitor #(
      .TIMEOUT_CYC(TB_TIMEOUT_CYC),
      .SLV_BUDGET_CYC(TB_SLV_BUDGET_CYC),
      .MST_BUDGET_CYC(TB_MST_BUDGET_CYC),
      .BUSOFF_CYC(TB_BUSOFF_CYC)
   ) dut (
      .clk(clk),
      .reset(reset),
      .bus_clock_line_i(scl),
      .bus_data_line_i(sda),
      .master_req(master_req),
      .stretch_req(stretch_req),
      .bus_clock_line_o(scl_o),
      .bus_clock_line_oe(scl_oe),
      .bus_data_line_oe(sda_oe),
      .in_message(in_message),
      .xact_abort(xact_abort),
      .bus_off(bus_off),
      .bus_ready(bus_ready),
      .slave_budget_over(slave_budget_over),
      .master_budget_over(master_budget_over),
      .master_active(master_active)
   );
   smbtm_host_model host (
      .clk(clk),
      .scl(scl),
      .clk_low(clk_low),
      .dat_low(dat_low)
   );
   // Counts abort pulses and cuts a hung run short
   always @(posedge clk) begin
      aborts <= aborts + (xact_abort === 1'b1);
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures++;
         wrap_up();
      end
   end
   // Prints the counts and the verdict, then ends the run
   task automatic wrap_up();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Clock low past the timeout abandons the message; no reply until a new start
   task automatic t_timeout();
      k = aborts;
      host.start();
      host.pulse(2);
      `CHK(in_message, 1'b1)
      host.drive(1'b1, 1'b0);
      host.idle(150);
      `CHK(aborts, k)
      host.idle(80);
      `CHK(aborts, k + 1)
      `CHK(in_message, 1'b0)
      host.drive(1'b0, 1'b0);
      host.pulse(3);
      `CHK(in_message, 1'b0)
      `CHK(scl_oe, 1'b0)
      `CHK(sda_oe, 1'b0)
   endtask
   // Clock high past 50 us resets the message
   task automatic t_idle();
      k = aborts;
      host.start();
      host.pulse(1);
      host.idle(450);
      `CHK(aborts, k)
      host.idle(80);
      `CHK(aborts, k + 1)
      `CHK(in_message, 1'b0)
   endtask
   // Own stretching adds up over one message and clears at the stop
   task automatic t_slave();
      host.start();
      repeat (3) begin
         stretch_req <= 1'b1;
         fork
            host.hold(4);
            begin
               host.idle(100);
               `CHK(scl_oe, 1'b1)
               host.idle(50);
               stretch_req <= 1'b0;
            end
         join
         host.idle(4);
      end
      `CHK(slave_budget_over, 1'b1)
      host.stop();
      `CHK(slave_budget_over, 1'b0)
   endtask
   // Long clock lows from the far master add up against its budget
   task automatic t_mext();
      host.start();
      host.pulse(1);
      `CHK(master_budget_over, 1'b0)
      repeat (3) host.hold(180);
      `CHK(master_budget_over, 1'b1)
      host.stop();
      `CHK(master_budget_over, 1'b0)
   endtask
   // Both lines low enter bus-off; master requests refused while off, then ready again after recovery
   task automatic t_busoff();
      host.drive(1'b1, 1'b1);
      host.idle(60);
      `CHK(bus_off, 1'b1)
      `CHK(bus_ready, 1'b0)
      master_req <= 1'b1;
      host.idle(10);
      `CHK(master_active, 1'b0)
      master_req <= 1'b0;
      host.drive(1'b0, 1'b0);
      host.idle(6);
      `CHK(bus_off, 1'b0)
      k = 0;
      while (bus_ready !== 1'b1 && k < 10100) begin
         host.idle(1);
         k++;
      end
      `CHK(bus_ready, 1'b1)
   endtask
   // Master clock generator runs at the documented half period
   task automatic t_master();
      master_req <= 1'b1;
      k = 0;
      while (scl_oe !== 1'b1 && k < 3000) begin
         host.idle(1);
         k++;
      end
      `CHK(master_active, 1'b1)
      k = 0;
      while (scl_oe === 1'b1 && k < 300) begin
         host.idle(1);
         k++;
      end
      `CHK(k, smbtm_pkg::MCLK_HALF_CYC)
      `CHK(scl_o, 1'b0)
   endtask
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      master_req = 1'b0;
      stretch_req = 1'b0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      `CHK(bus_ready, 1'b1)
      `CHK(scl_oe, 1'b0)
      t_timeout();
      t_idle();
      t_slave();
      t_mext();
      t_busoff();
      t_master();
      wrap_up();
   end
endmodule // smbtm_monitor_tb
`default_nettype wire
